//--- inc/bsc_pkg.sv
// Package of constants for the brushless sine commutation init block
package bsc_pkg;
    // ********************
    // Register offsets
    // ********************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_MODULUS = 8'h08;
    localparam logic [7:0] ADDR_VLIMIT = 8'h0C;
    localparam logic [7:0] ADDR_TIMEOUT = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_ERROR = 8'h18;
    localparam logic [7:0] ADDR_ANGLE = 8'h1C;
    localparam logic [7:0] ADDR_POS = 8'h20;
    localparam logic [7:0] ADDR_HALL = 8'h24;
    // ********************
    // Field positions
    // ********************
    localparam int CTRL_AXIS_SEL = 0;
    localparam int CTRL_TWO_PHASE = 1;
    localparam int CMD_ALIGN = 0;
    localparam int CMD_SEARCH = 1;
    localparam int CMD_HALL_INIT = 2;
    localparam int CMD_REFINE = 3;
    localparam int CMD_SERVO_ON = 4;
    localparam int CMD_MOTOR_OFF = 5;
    // ********************
    // Reset values
    // ********************
    localparam logic [31:0] MODULUS_RST = 32'h0000_0FA0;
    localparam logic [15:0] VLIMIT_RST = 16'h0000;
    localparam logic [15:0] TIMEOUT_MS_RST = 16'h03E8;
    // ********************
    // Error codes and hall values
    // ********************
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_ALIGN_TIMEOUT = 8'h70;
    localparam logic [7:0] ERR_ALIGN_RUNAWAY = 8'h72;
    localparam logic [7:0] ERR_SEARCH_FAIL = 8'hA0;
    localparam int HALL_A = 0;
    localparam int HALL_B = 1;
    localparam int HALL_C = 2;
    // ********************
    // Angles, in units of 1/360 of a magnetic cycle
    // ********************
    localparam logic [8:0] DEG_FULL = 9'h168;
    localparam logic [8:0] SEARCH_MAX_DEG = 9'h00A;
    localparam logic [8:0] SNAP_STEP_DEG = 9'h00F;
    localparam logic [8:0] SEARCH_STEP_DEG = 9'h001;
    // ********************
    // Timing
    // ********************
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int SETTLE_MS = 1;
    localparam logic [31:0] RUNAWAY_COUNTS = 32'h0000_0800;
    localparam logic [7:0] SEARCH_MOVE_COUNTS = 8'h40;
endpackage

//--- verilog/bsc_hall_decode.sv
// Hall state formation and phase estimate lookup
`timescale 1ns/1ps
module bsc_hall_decode (
    // Raw hall pins
    input wire logic hall_a,
    input wire logic hall_b,
    input wire logic hall_c,
    // Decoded state
    output logic [2:0] hall_state,
    output logic [8:0] est_deg,
    output logic valid
);
    // ********************
    // Decode
    // ********************
    always_comb begin
        hall_state = {hall_c, hall_b, hall_a};
        valid = 1'b1;
        // Halls centred on AB, BC, CA excitation; forward order 1 3 2 6 4 5
        case ({hall_c, hall_b, hall_a})
            3'h1: est_deg = 9'h000;
            3'h3: est_deg = 9'h03C;
            3'h2: est_deg = 9'h078;
            3'h6: est_deg = 9'h0B4;
            3'h4: est_deg = 9'h0F0;
            3'h5: est_deg = 9'h12C;
            default: begin
                est_deg = 9'h000;
                valid = 1'b0;
            end
        endcase
    end
endmodule

//--- verilog/bsc_commutation_init.sv
// Sine commutation initialisation for one brushless axis, Wishbone slave
//
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
// Function
// - Alignment drives two of three phases to zero degrees, then starts sine drive.
// - Search moves at most 10 degrees, then snaps to nearest 15 degree step.
// - Hall init with argument -1 starts pseudo-trapezoidal drive from hall estimate.
// - Armed refine replaces estimate at first hall edge, then pure sine drive.
// - Modulus holds counts per magnetic cycle; commutation angle wraps on it.
// - Alignment and search never exceed the programmed voltage limit.
// - Alignment runaway records 114; search failure records 160; error readable.
// - Alignment timeout records 112; timeout programmable, default 1000 ms.
// - Forward hall order is 1 3 2 6 4 5; order is checked.
// - Hall estimate assumes halls A, B, C on phase pairs AB, BC, CA.
// - Commutation state is invalid after every reset until reinitialised.
// - Two-phase motors align with one fixed two-phase pattern.
// - Axis must be selected before modulus and initialisation take effect.
// - Servo-on enables the amplifier, motor-off disables outside alignment, search and snap, which enable it too; motion only when enabled.
module bsc_commutation_init #(
    parameter int TIMEOUT_CYC_PER_MS = bsc_pkg::CYC_PER_MS
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // Wishbone slave
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    // Encoder and halls
    input wire logic [31:0] ENC_POS,
    input wire logic HALL_A,
    input wire logic HALL_B,
    input wire logic HALL_C,
    // Amplifier
    output logic AMP_EN,
    output logic [8:0] PHASE_ANGLE,
    output logic [15:0] DRIVE_LEVEL,
    output logic [2:0] PHASE_MASK,
    output logic SINE_MODE,
    output logic TRAP_MODE
);
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ALIGN = 6'b000010,
        ST_SEARCH = 6'b000100,
        ST_SNAP = 6'b001000,
        ST_TRAP = 6'b010000,
        ST_SINE = 6'b100000
    } bsc_state_t;

    // ********************
    // Helpers
    // ********************
    function automatic logic [8:0] wrap_deg(input logic [9:0] d);
        wrap_deg = (d >= {1'b0, bsc_pkg::DEG_FULL}) ? 9'(d - {1'b0, bsc_pkg::DEG_FULL})
                                                     : d[8:0];
    endfunction
    function automatic logic [8:0] snap_deg(input logic [8:0] d);
        logic [8:0] r;
        r = 9'(d % bsc_pkg::SNAP_STEP_DEG);
        snap_deg = (r > 9'h007) ? wrap_deg(10'(d - r) + 10'(bsc_pkg::SNAP_STEP_DEG)) : 9'(d - r);
    endfunction

    bsc_state_t state_q;
    logic ack_q, axis_sel_q, two_phase_q, amp_en_q, refine_armed_q, valid_q;
    logic [31:0] modulus_q, pos0_q, tick_pos_q, enc_rel_q;
    logic [15:0] vlimit_q, timeout_ms_q, ms_q, cyc_q;
    logic [7:0] err_q;
    logic [8:0] offset_q, search_q;
    logic [2:0] hall_q, hall_prev_q;
    logic hall_order_err_q, hall_seen_fwd_q;
    logic [2:0] hall_state;
    logic [8:0] hall_est;
    logic hall_ok;

    bsc_hall_decode u_hall (
        .hall_a(HALL_A),
        .hall_b(HALL_B),
        .hall_c(HALL_C),
        .hall_state(hall_state),
        .est_deg(hall_est),
        .valid(hall_ok)
    );

    wire req = CYC_I && STB_I && !ack_q;
    wire wr = req && WE_I;
    wire cmd_wr = wr && ADR_I == bsc_pkg::ADDR_CMD && SEL_I[0];
    wire [31:0] disp = ENC_POS - pos0_q;
    wire hall_edge = hall_q != hall_prev_q;

    // ********************
    // Bus answer
    // ********************
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ack_q <= 1'b0;
            DAT_O <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (req && !WE_I) begin
                case (ADR_I)
                    bsc_pkg::ADDR_CTRL: DAT_O <= {30'h0, two_phase_q, axis_sel_q};
                    bsc_pkg::ADDR_MODULUS: DAT_O <= modulus_q;
                    bsc_pkg::ADDR_VLIMIT: DAT_O <= {16'h0, vlimit_q};
                    bsc_pkg::ADDR_TIMEOUT: DAT_O <= {16'h0, timeout_ms_q};
                    bsc_pkg::ADDR_STATUS: DAT_O <= {24'h0, hall_order_err_q, valid_q,
                                                    refine_armed_q, amp_en_q, state_q[5:2]};
                    bsc_pkg::ADDR_ERROR: DAT_O <= {24'h0, err_q};
                    bsc_pkg::ADDR_ANGLE: DAT_O <= {23'h0, PHASE_ANGLE};
                    bsc_pkg::ADDR_POS: DAT_O <= ENC_POS;
                    bsc_pkg::ADDR_HALL: DAT_O <= {29'h0, hall_state};
                    default: DAT_O <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign ACK_O = ack_q;

    // ********************
    // Configuration
    // ********************
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            axis_sel_q <= 1'b0;
            two_phase_q <= 1'b0;
            modulus_q <= bsc_pkg::MODULUS_RST;
            vlimit_q <= bsc_pkg::VLIMIT_RST;
            timeout_ms_q <= bsc_pkg::TIMEOUT_MS_RST;
        end else if (wr) begin
            case (ADR_I)
                bsc_pkg::ADDR_CTRL: begin
                    axis_sel_q <= DAT_I[bsc_pkg::CTRL_AXIS_SEL];
                    two_phase_q <= DAT_I[bsc_pkg::CTRL_TWO_PHASE];
                end
                bsc_pkg::ADDR_MODULUS: if (axis_sel_q) modulus_q <= DAT_I;
                bsc_pkg::ADDR_VLIMIT: vlimit_q <= DAT_I[15:0];
                bsc_pkg::ADDR_TIMEOUT: timeout_ms_q <= DAT_I[15:0];
                default: ;
            endcase
        end
    end

    // ********************
    // Amplifier enable
    // ********************
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            amp_en_q <= 1'b0;
        end else if (cmd_wr && DAT_I[bsc_pkg::CMD_MOTOR_OFF]) begin
            amp_en_q <= 1'b0;
        end else if (cmd_wr && DAT_I[bsc_pkg::CMD_SERVO_ON]) begin
            amp_en_q <= 1'b1;
        end
    end
    assign AMP_EN = amp_en_q || state_q == ST_ALIGN || state_q == ST_SEARCH
                    || state_q == ST_SNAP;

    // ********************
    // Hall monitor
    // ********************
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            hall_q <= 3'h0;
            hall_prev_q <= 3'h0;
            hall_order_err_q <= 1'b0;
            hall_seen_fwd_q <= 1'b0;
        end else begin
            hall_q <= hall_state;
            hall_prev_q <= hall_q;
            // Reverse step or illegal code flags miswiring; sticky until reset
            if (hall_edge && hall_prev_q != 3'h0) begin
                case ({hall_prev_q, hall_q})
                    6'h0B, 6'h1A, 6'h16, 6'h34, 6'h25, 6'h29: hall_seen_fwd_q <= 1'b1;
                    default: hall_order_err_q <= 1'b1;
                endcase
            end
        end
    end

    // ********************
    // Initialisation sequencer
    // ********************
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state_q <= ST_IDLE;
            valid_q <= 1'b0;
            err_q <= bsc_pkg::ERR_NONE;
            offset_q <= 9'h000;
            search_q <= 9'h000;
            pos0_q <= 32'h0000_0000;
            tick_pos_q <= 32'h0000_0000;
            ms_q <= 16'h0000;
            cyc_q <= 16'h0000;
            refine_armed_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE, ST_SINE: begin
                    ms_q <= 16'h0000;
                    cyc_q <= 16'h0000;
                    pos0_q <= ENC_POS;
                    tick_pos_q <= ENC_POS;
                    search_q <= 9'h000;
                    if (cmd_wr && axis_sel_q) begin
                        if (DAT_I[bsc_pkg::CMD_ALIGN]) begin
                            state_q <= ST_ALIGN;
                            valid_q <= 1'b0;
                        end else if (DAT_I[bsc_pkg::CMD_SEARCH]) begin
                            state_q <= ST_SEARCH;
                            valid_q <= 1'b0;
                        end else if (DAT_I[bsc_pkg::CMD_HALL_INIT] && DAT_I[31] && hall_ok) begin
                            offset_q <= hall_est;
                            state_q <= ST_TRAP;
                            valid_q <= 1'b0;
                        end
                    end
                end
                ST_ALIGN: begin
                    // Whole-ms tick; timeout counts every ms in alignment, whether the rotor moves or not
                    if (cyc_q == 16'(TIMEOUT_CYC_PER_MS - 1)) begin
                        cyc_q <= 16'h0000;
                        ms_q <= ms_q + 16'h0001;
                    end else begin
                        cyc_q <= cyc_q + 16'h0001;
                    end
                    if (disp > bsc_pkg::RUNAWAY_COUNTS && -disp > bsc_pkg::RUNAWAY_COUNTS) begin
                        err_q <= bsc_pkg::ERR_ALIGN_RUNAWAY;
                        state_q <= ST_IDLE;
                    end else if (ms_q >= timeout_ms_q) begin
                        err_q <= bsc_pkg::ERR_ALIGN_TIMEOUT;
                        state_q <= ST_IDLE;
                    end else if (ms_q >= 16'(bsc_pkg::SETTLE_MS) && cyc_q == 16'h0000
                                 && ENC_POS == tick_pos_q) begin
                        offset_q <= phase_off(9'h000, ENC_POS);
                        valid_q <= 1'b1;
                        err_q <= bsc_pkg::ERR_NONE;
                        state_q <= ST_SINE;
                    end
                    if (ms_q != 16'h0000 && cyc_q == 16'h0000) begin
                        tick_pos_q <= ENC_POS;
                    end
                end
                ST_SEARCH: begin
                    if (disp[31] ? (-disp > 32'(bsc_pkg::SEARCH_MOVE_COUNTS))
                                 : (disp > 32'(bsc_pkg::SEARCH_MOVE_COUNTS))) begin
                        err_q <= bsc_pkg::ERR_SEARCH_FAIL;
                        state_q <= ST_IDLE;
                    end else if (search_q >= bsc_pkg::SEARCH_MAX_DEG) begin
                        state_q <= ST_SNAP;
                    end else if (cyc_q == 16'(bsc_pkg::SETTLE_MS * TIMEOUT_CYC_PER_MS - 1)) begin
                        cyc_q <= 16'h0000;
                        search_q <= search_q + bsc_pkg::SEARCH_STEP_DEG;
                    end else begin
                        cyc_q <= cyc_q + 16'h0001;
                    end
                end
                ST_SNAP: begin
                    offset_q <= phase_off(snap_deg(wrap_deg(10'(search_q)
                        + 10'(enc_deg(disp)))), ENC_POS);
                    valid_q <= 1'b1;
                    err_q <= bsc_pkg::ERR_NONE;
                    state_q <= ST_SINE;
                end
                ST_TRAP: begin
                    if (cmd_wr && DAT_I[bsc_pkg::CMD_REFINE]) begin
                        refine_armed_q <= 1'b1;
                    end
                    if (refine_armed_q && hall_edge && hall_ok) begin
                        // Hall edge sits midway between two sector centres
                        offset_q <= phase_off(wrap_deg(10'(hall_est) + 10'h14A), ENC_POS);
                        refine_armed_q <= 1'b0;
                        valid_q <= 1'b1;
                        state_q <= ST_SINE;
                    end else if (hall_ok) begin
                        offset_q <= hall_est;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ********************
    // Commutation angle
    // ********************
    function automatic logic [8:0] enc_deg(input logic [31:0] p);
        logic [31:0] m;
        logic [40:0] s;
        m = (modulus_q == 32'h0) ? 32'h1 : modulus_q;
        s = 41'(p % m) * 41'(bsc_pkg::DEG_FULL);
        enc_deg = 9'(s / 41'(m));
    endfunction
    function automatic logic [8:0] phase_off(input logic [8:0] a, input logic [31:0] p);
        phase_off = wrap_deg(10'(a) + 10'(bsc_pkg::DEG_FULL) - 10'(enc_deg(p)));
    endfunction

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            enc_rel_q <= 32'h0000_0000;
        end else begin
            enc_rel_q <= ENC_POS % ((modulus_q == 32'h0) ? 32'h1 : modulus_q);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            PHASE_ANGLE <= 9'h000;
            PHASE_MASK <= 3'h0;
            DRIVE_LEVEL <= 16'h0000;
            SINE_MODE <= 1'b0;
            TRAP_MODE <= 1'b0;
        end else begin
            SINE_MODE <= state_q == ST_SINE && valid_q && amp_en_q;
            TRAP_MODE <= state_q == ST_TRAP && amp_en_q;
            case (state_q)
                ST_ALIGN: begin
                    PHASE_ANGLE <= 9'h000;
                    // A and B on either motor kind
                    PHASE_MASK <= 3'h3;
                    DRIVE_LEVEL <= vlimit_q;
                end
                ST_SEARCH, ST_SNAP: begin
                    PHASE_ANGLE <= search_q;
                    PHASE_MASK <= 3'h7;
                    DRIVE_LEVEL <= vlimit_q;
                end
                ST_TRAP: begin
                    PHASE_ANGLE <= offset_q;
                    PHASE_MASK <= 3'h7;
                    DRIVE_LEVEL <= amp_en_q ? 16'hFFFF : 16'h0000;
                end
                ST_SINE: begin
                    PHASE_ANGLE <= wrap_deg({1'b0, enc_deg(enc_rel_q)} + {1'b0, offset_q});
                    PHASE_MASK <= 3'h7;
                    DRIVE_LEVEL <= amp_en_q ? 16'hFFFF : 16'h0000;
                end
                default: begin
                    PHASE_ANGLE <= 9'h000;
                    PHASE_MASK <= 3'h0;
                    DRIVE_LEVEL <= 16'h0000;
                end
            endcase
        end
    end
endmodule

//--- tb/bsc_commutation_init_assertions.sv
// Checker of drive outputs and hall readback of the commutation init block
`timescale 1ns/1ps
module bsc_checker (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // Bus
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    input wire logic [31:0] DAT_O,
    input wire logic ACK_O,
    // Motor side
    input wire logic [31:0] ENC_POS,
    input wire logic HALL_A,
    input wire logic HALL_B,
    input wire logic HALL_C,
    input wire logic AMP_EN,
    input wire logic [8:0] PHASE_ANGLE,
    input wire logic [15:0] DRIVE_LEVEL,
    input wire logic [2:0] PHASE_MASK,
    input wire logic SINE_MODE,
    input wire logic TRAP_MODE
);
    logic req, cmd_wr, hall_rd, sel_q;
    logic [15:0] vlim_q;
    logic [2:0] hall_w;
    assign req = CYC_I && STB_I && !ACK_O;
    assign cmd_wr = req && WE_I && ADR_I == bsc_pkg::ADDR_CMD && SEL_I[0];
    assign hall_rd = req && !WE_I && ADR_I == bsc_pkg::ADDR_HALL;
    assign hall_w = {HALL_C, HALL_B, HALL_A};
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sel_q <= 1'h0;
            vlim_q <= bsc_pkg::VLIMIT_RST;
        end else if (req && WE_I && ADR_I == bsc_pkg::ADDR_CTRL) begin
            sel_q <= DAT_I[0];
        end else if (req && WE_I && ADR_I == bsc_pkg::ADDR_VLIMIT) begin
            vlim_q <= DAT_I[15:0];
        end
    end
    // ********************
    // Properties
    // ********************
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);
    a_reset_quiet: assert property ($past(RST) |-> !AMP_EN && !SINE_MODE && !TRAP_MODE)
        else $error("drive active right after reset");
    a_angle_wrap: assert property (PHASE_ANGLE < bsc_pkg::DEG_FULL)
        else $error("angle beyond one magnetic cycle");
    a_drive_limit: assert property (AMP_EN && $past(AMP_EN) && !SINE_MODE && !TRAP_MODE
        |-> DRIVE_LEVEL <= vlim_q) else $error("drive above limit during init");
    a_align_pair: assert property (cmd_wr && DAT_I[0] && sel_q
        |-> ##[1:3] $countones(PHASE_MASK) == 2) else $error("alignment not on two phases");
    a_unselected_idle: assert property (cmd_wr && DAT_I[1:0] != 2'h0 && !sel_q && !AMP_EN
        |=> !AMP_EN [*3]) else $error("init ran without axis select");
    a_servo_on: assert property (cmd_wr && DAT_I[4] && !DAT_I[5] |=> AMP_EN)
        else $error("servo on left amplifier off");
    a_motor_off: assert property (cmd_wr && DAT_I[5] && (SINE_MODE || TRAP_MODE)
        |=> ##1 !AMP_EN && !SINE_MODE) else $error("motor off left drive on");
    a_hall_code: assert property (hall_rd && $stable(hall_w) && hall_w == $past(hall_w, 2)
        |=> DAT_O[2:0] == $past(hall_w)) else $error("hall code bits misplaced");
    a_modes_apart: assert property (!(SINE_MODE && TRAP_MODE))
        else $error("sine and trapezoid drive together");
    c_sine: cover property (SINE_MODE);
    c_refine: cover property (TRAP_MODE ##[1:4] SINE_MODE);
    c_align: cover property ($countones(PHASE_MASK) == 2);
endmodule

bind bsc_commutation_init bsc_checker u_bsc_checker (
    .CLK_SYS(CLK_SYS), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
    .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .ENC_POS(ENC_POS),
    .HALL_A(HALL_A), .HALL_B(HALL_B), .HALL_C(HALL_C), .AMP_EN(AMP_EN),
    .PHASE_ANGLE(PHASE_ANGLE), .DRIVE_LEVEL(DRIVE_LEVEL), .PHASE_MASK(PHASE_MASK),
    .SINE_MODE(SINE_MODE), .TRAP_MODE(TRAP_MODE));

//--- tb/bsc_motor_model.sv
// Behavioural motor with encoder and halls for the commutation bench
`timescale 1ns/1ps
module bsc_motor_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Drive from the block
    input wire logic amp_en,
    input wire logic [2:0] phase_mask,
    // Bench controls: 0 settles, 1 runs away, 2 creeps
    input wire logic [1:0] mode,
    input wire logic hall_step,
    // Feedback
    output logic [31:0] enc_pos,
    output logic hall_a,
    output logic hall_b,
    output logic hall_c
);
    // Forward order of a correctly wired motor
    localparam logic [17:0] ORDER = {3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
    logic [2:0] sector_q;
    logic [1:0] div_q;
    logic moving;
    assign moving = amp_en && phase_mask != 3'h0;
    assign {hall_c, hall_b, hall_a} = ORDER[sector_q * 3 +: 3];
    // Creep needs over 8000 clocks of alignment to count as runaway, yet never settles
    always_ff @(posedge clk) begin
        if (rst) begin
            enc_pos <= 32'h0;
            sector_q <= 3'h0;
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
            if (hall_step) begin
                sector_q <= (sector_q == 3'h5) ? 3'h0 : sector_q + 3'h1;
                enc_pos <= enc_pos + 32'h1;
            end else if (moving && (mode == 2'h1 || (mode == 2'h2 && div_q == 2'h0))) begin
                enc_pos <= enc_pos + 32'h1;
            end
        end
    end
endmodule

//--- tb/tb_bsc_commutation_init.sv
// Self-checking bench of the commutation init block with a motor model
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin miscompares++; \
    $display("mismatch %s expected %0h seen %0h", n, e, s); end end
module tb_bsc_commutation_init;
    logic clk_sys, rst, cyc, stb, we, ack, amp_en, sine, trap, hall_a, hall_b, hall_c, hall_step;
    logic [1:0] mode;
    logic [2:0] mask;
    logic [7:0] adr;
    logic [8:0] angle;
    logic [31:0] dat_w, dat_r, enc_pos, rd, val;
    int miscompares, comparisons, n, seed;
    initial begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end
    bsc_commutation_init #(.TIMEOUT_CYC_PER_MS(10)) u_bsc_commutation_init (
        .CLK_SYS(clk_sys), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(4'hF), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .ENC_POS(enc_pos),
        .HALL_A(hall_a), .HALL_B(hall_b), .HALL_C(hall_c), .AMP_EN(amp_en),
        .PHASE_ANGLE(angle), .DRIVE_LEVEL(), .PHASE_MASK(mask), .SINE_MODE(sine),
        .TRAP_MODE(trap));
    bsc_motor_model u_bsc_motor_model (.clk(clk_sys), .rst(rst), .amp_en(amp_en),
        .phase_mask(mask), .mode(mode), .hall_step(hall_step), .enc_pos(enc_pos),
        .hall_a(hall_a), .hall_b(hall_b), .hall_c(hall_c));
    function automatic logic [2:0] hall_exp(input int s);
        logic [17:0] order;
        order = {3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
        return order[(s % 6) * 3 +: 3];
    endfunction
    function automatic logic [7:0] err_exp(input int i);
        case (i)
            1: return 8'h72;
            2: return 8'h70;
            4: return 8'hA0;
            default: return 8'h00;
        endcase
    endfunction
    task automatic test_done();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge clk_sys);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        dat_w <= d;
        t = 0;
        do begin
            @(posedge clk_sys);
            t++;
        end while (ack !== 1'h1 && t < 20);
        if (ack !== 1'h1) begin
            miscompares++;
            test_done();
        end
        rd = dat_r;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask
    task automatic step_hall();
        hall_step <= 1'h1;
        @(posedge clk_sys);
        hall_step <= 1'h0;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic wait_amp_off();
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (amp_en !== 1'h0 && n < 9000);
        if (amp_en !== 1'h0) begin
            miscompares++;
            test_done();
        end
    endtask
    // ********************
    // Main sequence
    // ********************
    initial begin
        seed = 32'h6043;
        rst = 1'h1;
        cyc = 1'h0;
        stb = 1'h0;
        we = 1'h0;
        adr = 8'h00;
        dat_w = 32'h0;
        mode = 2'h0;
        hall_step = 1'h0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'h0;
        bus(1'h0, bsc_pkg::ADDR_MODULUS, 32'h0);
        `CHK("modulus", 32'hFA0, rd);
        bus(1'h0, bsc_pkg::ADDR_TIMEOUT, 32'h0);
        `CHK("timeout", 32'h3E8, rd);
        bus(1'h0, bsc_pkg::ADDR_STATUS, 32'h0);
        `CHK("valid", 1'h0, rd[6]);
        bus(1'h0, 8'h3C, 32'h0);
        `CHK("unmapped", 32'h0, rd);
        for (int s = 0; s < 7; s++) begin
            bus(1'h0, bsc_pkg::ADDR_HALL, 32'h0);
            `CHK("hall", hall_exp(s), rd[2:0]);
            step_hall();
        end
        bus(1'h1, bsc_pkg::ADDR_CMD, 32'h1);
        bus(1'h1, bsc_pkg::ADDR_MODULUS, 32'h123);
        bus(1'h0, bsc_pkg::ADDR_STATUS, 32'h0);
        `CHK("amp unselected", 1'h0, amp_en);
        bus(1'h0, bsc_pkg::ADDR_MODULUS, 32'h0);
        `CHK("modulus unselected", 32'hFA0, rd);
        val = 32'h200 + ($random(seed) & 32'hFFF);
        bus(1'h1, bsc_pkg::ADDR_CTRL, 32'h1);
        bus(1'h1, bsc_pkg::ADDR_MODULUS, val);
        bus(1'h0, bsc_pkg::ADDR_MODULUS, 32'h0);
        `CHK("modulus", val, rd);
        for (int i = 0; i < 6; i++) begin
            mode <= (i == 1 || i == 4) ? 2'h1 : (i == 2) ? 2'h2 : 2'h0;
            bus(1'h1, bsc_pkg::ADDR_CTRL, (i == 5) ? 32'h3 : 32'h1);
            bus(1'h1, bsc_pkg::ADDR_VLIMIT, 32'h100 + ($random(seed) & 32'h3FFF));
            bus(1'h1, bsc_pkg::ADDR_TIMEOUT, (i == 1) ? 32'h1F4 : (i == 2) ? 32'h2 : 32'h5);
            bus(1'h1, bsc_pkg::ADDR_CMD, (i == 3 || i == 4) ? 32'h2 : 32'h1);
            wait_amp_off();
            bus(1'h0, bsc_pkg::ADDR_ERROR, 32'h0);
            `CHK("error", err_exp(i), rd[7:0]);
            if (err_exp(i) == 8'h00) begin
                bus(1'h1, bsc_pkg::ADDR_CMD, 32'h10);
                repeat (3) @(posedge clk_sys);
                `CHK("sine on", 2'h3, {sine, amp_en});
                `CHK("snap", 9'h000, angle % 9'h00F);
                bus(1'h1, bsc_pkg::ADDR_CMD, 32'h20);
                repeat (3) @(posedge clk_sys);
                `CHK("amp off", 1'h0, amp_en);
            end
        end
        mode <= 2'h0;
        bus(1'h1, bsc_pkg::ADDR_CMD, 32'h4);
        bus(1'h0, bsc_pkg::ADDR_STATUS, 32'h0);
        `CHK("trap without arg", 1'h0, rd[2]);
        bus(1'h1, bsc_pkg::ADDR_CMD, 32'h8000_0004);
        bus(1'h1, bsc_pkg::ADDR_CMD, 32'h18);
        bus(1'h0, bsc_pkg::ADDR_STATUS, 32'h0);
        `CHK("trap armed", 2'h3, {rd[5], rd[2]});
        `CHK("trap port", 1'h1, trap);
        step_hall();
        n = 0;
        while (sine !== 1'h1 && n < 50) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK("refined", 2'h2, {sine, trap});
        // Reset in mid-run drops commutation
        rst <= 1'h1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        `CHK("sine after reset", 1'h0, sine);
        bus(1'h0, bsc_pkg::ADDR_STATUS, 32'h0);
        `CHK("valid after reset", 1'h0, rd[6]);
        test_done();
    end
endmodule
